// *** src/iid_regs.vh ***
// Constants for the input image and diagnostic event block.
// Assumes a 50 MHz system clock and a 32-bit Avalon-MM register port.
`ifndef IID_REGS_VH
`define IID_REGS_VH

// ==========================================================================
// Clock and timing
`define IID_CLK_HZ            50000000
`define IID_CYC_PER_MS        (`IID_CLK_HZ / 1000)
`define IID_FLASH_HALF_MS     500

// ==========================================================================
// Register byte offsets
`define IID_ADDR_W            5
`define IID_OFS_CTRL          5'h00
`define IID_OFS_IMAGE         5'h04
`define IID_OFS_IO_STATUS     5'h08
`define IID_OFS_IRQ_STATUS    5'h0C
`define IID_OFS_IRQ_MASK      5'h10
`define IID_OFS_IN_DELAY      5'h14
`define IID_OFS_OUT_DELAY     5'h18
`define IID_OFS_FAULT         5'h1C

// ==========================================================================
// Control register fields
`define IID_CTRL_MODE_BIT     0
`define IID_CTRL_RESTORE_BIT  1
`define IID_CTRL_ACTIVE_BIT   2
`define IID_MODE_BM_EVENT     1'b0
`define IID_MODE_NET_TIME     1'b1

// ==========================================================================
// Status word and interrupt fields
`define IID_IOS_OVERLOAD_BIT  4
`define IID_IOS_UNDERVOLT_BIT 5
`define IID_IRQ_W             3
`define IID_IRQ_IMAGE_BIT     0
`define IID_IRQ_EMCY_BIT      1
`define IID_IRQ_FAULT_BIT     2

// ==========================================================================
// Fault sources and emergency message contents
`define IID_SRC_OVERCURRENT   2'h0
`define IID_SRC_SURGE         2'h1
`define IID_SRC_UNDERVOLT     2'h2
`define IID_SRC_OVERTEMP      2'h3
`define IID_CODE_OVERCURRENT  16'h3001
`define IID_CODE_SURGE        16'h3002
`define IID_CODE_UNDERVOLT    16'h3003
`define IID_CODE_OVERTEMP     16'h4001
`define IID_CODE_RESET        16'h0000
`define IID_ERREG_SUPPLY_BIT  2
`define IID_ERREG_TEMP_BIT    4
`define IID_DIAG_OVERCURRENT  8'h01
`define IID_DIAG_SURGE        8'h02
`define IID_DIAG_UNDERVOLT    8'h03
`define IID_DIAG_OVERTEMP     8'h06
`define IID_MSG_BYTES         4'h8

// ==========================================================================
// Reset values
`define IID_RST_IN_DELAY      16'h0001
`define IID_RST_OUT_DELAY     16'h0001
`define IID_RST_WORD          32'h0000_0000

`endif

// *** src/iid_sync3.v ***
// Three-stage synchroniser for a group of asynchronous pins.
// Assumes each bit changes slowly compared with the system clock.
`timescale 1ns/1ns
module iid_sync3 #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         i_clk_sys,
  input  wire         i_rst_n,
  // Pins and synchronised levels
  input  wire [W-1:0] i_async,
  output reg  [W-1:0] o_level
);

  reg [W-1:0] stage1;
  reg [W-1:0] stage2;
  reg [W-1:0] stage3;
  integer     k;

  // ========================================================================
  // Chain; a bit is accepted once stages two and three agree
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage1  <= {W{1'b0}};
      stage2  <= {W{1'b0}};
      stage3  <= {W{1'b0}};
      o_level <= {W{1'b0}};
    end else begin
      stage1 <= i_async;
      stage2 <= stage1;
      stage3 <= stage2;
      for (k = 0; k < W; k = k + 1) begin
        if (stage2[k] == stage3[k]) begin
          o_level[k] <= stage3[k];
        end
      end
    end
  end

endmodule

// *** src/iid_emcy_tx.v ***
// Emergency message serialiser: eight bytes out, least significant first.
// Assumes the link side accepts a byte on valid and ready; no reply exists.
`timescale 1ns/1ns
`include "iid_regs.vh"
module iid_emcy_tx (
  // Clock and reset
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  // Message load
  input  wire        i_start,
  input  wire [63:0] i_msg,
  // Byte stream
  output reg  [7:0]  o_byte,
  output reg         o_valid,
  output reg         o_last,
  input  wire        i_ready
);

  reg [63:0] shift;
  reg [3:0]  left;

  // ========================================================================
  // Load, then shift one byte per accepted beat
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift   <= 64'h0000_0000_0000_0000;
      left    <= 4'h0;
      o_byte  <= 8'h00;
      o_valid <= 1'b0;
      o_last  <= 1'b0;
    end else if (i_start && !o_valid) begin
      shift   <= {8'h00, i_msg[63:8]};
      o_byte  <= i_msg[7:0];
      left    <= `IID_MSG_BYTES - 4'h1;
      o_valid <= 1'b1;
      o_last  <= 1'b0;
    end else if (o_valid && i_ready) begin
      if (left == 4'h0) begin
        o_valid <= 1'b0;
        o_last  <= 1'b0;
      end else begin
        o_byte <= shift[7:0];
        shift  <= {8'h00, shift[63:8]};
        left   <= left - 4'h1;
        o_last <= (left == 4'h1);
      end
    end
  end

endmodule

// *** src/iid_top.v ***
// Input process image, status word and emergency diagnostics for a
// sixteen-channel digital input fieldbus device.
// Assumes one 50 MHz clock, an Avalon-MM master for the registers, and a
// link engine that carries the image and the emergency byte stream.
//
// Overview of operation
// - Inputs one to eight fill image byte 0, nine to sixteen byte 1.
// - Status word bit 5 undervoltage, bit 4 overload; other bits read zero.
// - Emergency message: two-byte code, one-byte error register, five diagnostic bytes.
// - Codes 3001/3002/3003 set error bit 2, 4001 sets bit 4; diag 01/02/03/06.
// - Emergency messages go out unprompted and expect no acknowledgement.
// - A clearing fault sends code 0000, its error bit cleared unless another reported fault shares it, same diagnostic data.
// - Configuration picks the update trigger: buffer manager event or sync pulse.
// - In buffer manager mode inputs are sampled every clock, free running.
// - After reset the block works in buffer manager event mode.
// - In network time mode the image is output a set delay after sync.
// - In network time mode inputs are sampled a set delay after sync.
// - Writing one to restore requests defaults, applied at the next power-on.
// - After boot the ready lamp is steady or flashing by bus state.
// - Multi-byte fields leave least significant byte first.
`timescale 1ns/1ns
`include "iid_regs.vh"
module iid_top #(
  parameter N_IN       = 16,
  parameter FLASH_HALF = `IID_FLASH_HALF_MS * `IID_CYC_PER_MS
) (
  // Clock and reset
  input  wire                   i_clk_sys,
  input  wire                   i_rst_n,
  // Avalon-MM register slave
  input  wire [`IID_ADDR_W-1:0] i_avs_address,
  input  wire                   i_avs_read,
  input  wire                   i_avs_write,
  input  wire [31:0]            i_avs_writedata,
  output reg  [31:0]            o_avs_readdata,
  output reg                    o_avs_waitrequest,
  output reg                    o_irq,
  // Field pins
  input  wire [N_IN-1:0]        i_digital_input,
  input  wire                   i_fault_overcurrent,
  input  wire                   i_fault_surge,
  input  wire                   i_fault_undervolt,
  input  wire                   i_fault_overtemp,
  input  wire                   i_clock_sync_pulse,
  // Link engine side
  input  wire                   i_buffer_manager_event,
  input  wire                   i_restart,
  input  wire                   i_boot_done,
  input  wire                   i_bus_operational,
  output reg  [N_IN-1:0]        o_transmit_process_image,
  output reg                    o_image_strobe,
  output reg  [31:0]            o_io_status,
  output wire [7:0]             o_emcy_byte,
  output wire                   o_emcy_valid,
  output wire                   o_emcy_last,
  input  wire                   i_emcy_ready,
  // Device level outputs
  output reg                    o_mode_active,
  output reg                    o_restore_defaults_req,
  output reg                    o_ready_led
);

  // ========================================================================
  // Declarations
  wire [N_IN+4:0]          sync_level;
  wire [N_IN-1:0]          di_level;
  wire [3:0]               fault_now;
  wire                     sync_level_pulse;
  reg                      sync_prev;
  wire                     sync_rise;
  reg                      mode_req;
  reg  [15:0]              in_delay;
  reg  [15:0]              out_delay;
  reg  [15:0]              in_cnt;
  reg  [15:0]              out_cnt;
  reg                      in_run;
  reg                      out_run;
  reg  [N_IN-1:0]          sampled;
  reg  [`IID_IRQ_W-1:0]    irq_status;
  reg  [`IID_IRQ_W-1:0]    irq_mask;
  reg  [`IID_IRQ_W-1:0]    irq_set;
  reg  [3:0]               reported;
  reg  [3:0]               pending;
  reg  [7:0]               q_src;
  reg  [2:0]               q_cnt;
  reg                      enq;
  reg  [1:0]               enq_src;
  wire                     deq;
  wire [1:0]               deq_src;
  reg                      tx_start;
  reg  [63:0]              tx_msg;
  reg  [31:0]              flash_cnt;
  reg                      flash;
  reg  [31:0]              next_readdata;
  wire                     bus_req;
  wire                     wr_now;
  wire [7:0]               err_reg;
  integer                  i;

  // ========================================================================
  // Functions
  // Error code of a fault source
  function [15:0] code_of;
    input [1:0] src;
    begin
      case (src)
        `IID_SRC_OVERCURRENT: code_of = `IID_CODE_OVERCURRENT;
        `IID_SRC_SURGE:       code_of = `IID_CODE_SURGE;
        `IID_SRC_UNDERVOLT:   code_of = `IID_CODE_UNDERVOLT;
        default:              code_of = `IID_CODE_OVERTEMP;
      endcase
    end
  endfunction

  // Diagnostic identifier byte of a fault source
  function [7:0] diag_of;
    input [1:0] src;
    begin
      case (src)
        `IID_SRC_OVERCURRENT: diag_of = `IID_DIAG_OVERCURRENT;
        `IID_SRC_SURGE:       diag_of = `IID_DIAG_SURGE;
        `IID_SRC_UNDERVOLT:   diag_of = `IID_DIAG_UNDERVOLT;
        default:              diag_of = `IID_DIAG_OVERTEMP;
      endcase
    end
  endfunction

  // Delay counter step: zero delay still waits one clock
  function [15:0] load_of;
    input [15:0] d;
    begin
      load_of = (d == 16'h0000) ? 16'h0001 : d;
    end
  endfunction

  // ========================================================================
  // Pin synchronisers for inputs, faults and the sync pulse
  iid_sync3 #(
    .W (N_IN + 5)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_async   ({i_clock_sync_pulse, i_fault_overtemp, i_fault_undervolt,
                 i_fault_surge, i_fault_overcurrent, i_digital_input}),
    .o_level   (sync_level)
  );

  assign di_level         = sync_level[N_IN-1:0];
  assign fault_now        = sync_level[N_IN+3:N_IN];
  assign sync_level_pulse = sync_level[N_IN+4];
  assign sync_rise        = sync_level_pulse && !sync_prev;

  // ========================================================================
  // Avalon slave handshake: one wait cycle, then answer
  assign bus_req = i_avs_read || i_avs_write;
  assign wr_now  = i_avs_write && !o_avs_waitrequest;

  // Read multiplexer
  always @* begin
    next_readdata = `IID_RST_WORD;
    case (i_avs_address)
      `IID_OFS_CTRL: begin
        next_readdata[`IID_CTRL_MODE_BIT]    = mode_req;
        next_readdata[`IID_CTRL_RESTORE_BIT] = o_restore_defaults_req;
        next_readdata[`IID_CTRL_ACTIVE_BIT]  = o_mode_active;
      end
      `IID_OFS_IMAGE:      next_readdata[N_IN-1:0] = o_transmit_process_image;
      `IID_OFS_IO_STATUS:  next_readdata = o_io_status;
      `IID_OFS_IRQ_STATUS: next_readdata[`IID_IRQ_W-1:0] = irq_status;
      `IID_OFS_IRQ_MASK:   next_readdata[`IID_IRQ_W-1:0] = irq_mask;
      `IID_OFS_IN_DELAY:   next_readdata[15:0] = in_delay;
      `IID_OFS_OUT_DELAY:  next_readdata[15:0] = out_delay;
      `IID_OFS_FAULT:      next_readdata[11:0] = {pending, reported, fault_now};
      default:             next_readdata = `IID_RST_WORD;
    endcase
  end

  // Handshake and read data capture
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= `IID_RST_WORD;
    end else begin
      o_avs_waitrequest <= !(bus_req && o_avs_waitrequest);
      if (i_avs_read && o_avs_waitrequest) begin
        o_avs_readdata <= next_readdata;
      end
    end
  end

  // ========================================================================
  // Control registers written by software
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_req               <= `IID_MODE_BM_EVENT;
      o_restore_defaults_req <= 1'b0;
      irq_mask               <= {`IID_IRQ_W{1'b0}};
      in_delay               <= `IID_RST_IN_DELAY;
      out_delay              <= `IID_RST_OUT_DELAY;
    end else if (wr_now) begin
      case (i_avs_address)
        `IID_OFS_CTRL: begin
          mode_req <= i_avs_writedata[`IID_CTRL_MODE_BIT];
          if (i_avs_writedata[`IID_CTRL_RESTORE_BIT]) begin
            o_restore_defaults_req <= 1'b1;
          end
        end
        `IID_OFS_IRQ_MASK:  irq_mask  <= i_avs_writedata[`IID_IRQ_W-1:0];
        `IID_OFS_IN_DELAY:  in_delay  <= i_avs_writedata[15:0];
        `IID_OFS_OUT_DELAY: out_delay <= i_avs_writedata[15:0];
        default: begin
        end
      endcase
    end
  end

  // ========================================================================
  // Active mode, taken over only on a restart
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mode_active <= `IID_MODE_BM_EVENT;
    end else if (i_restart) begin
      o_mode_active <= mode_req;
    end
  end

  // ========================================================================
  // Network time mode delay counters after each sync pulse
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_prev <= 1'b0;
      in_cnt    <= 16'h0000;
      out_cnt   <= 16'h0000;
      in_run    <= 1'b0;
      out_run   <= 1'b0;
    end else begin
      sync_prev <= sync_level_pulse;
      if (o_mode_active == `IID_MODE_NET_TIME && sync_rise) begin
        in_cnt  <= load_of(in_delay);
        out_cnt <= load_of(out_delay);
        in_run  <= 1'b1;
        out_run <= 1'b1;
      end else begin
        if (in_run) begin
          in_cnt <= in_cnt - 16'h0001;
          in_run <= (in_cnt != 16'h0001);
        end
        if (out_run) begin
          out_cnt <= out_cnt - 16'h0001;
          out_run <= (out_cnt != 16'h0001);
        end
      end
    end
  end

  // ========================================================================
  // Input sampling and image publication
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sampled                  <= {N_IN{1'b0}};
      o_transmit_process_image <= {N_IN{1'b0}};
      o_image_strobe           <= 1'b0;
    end else begin
      o_image_strobe <= 1'b0;
      if (o_mode_active == `IID_MODE_BM_EVENT) begin
        sampled <= di_level;
        if (i_buffer_manager_event) begin
          o_transmit_process_image <= sampled;
          o_image_strobe           <= 1'b1;
        end
      end else begin
        if (in_run && in_cnt == 16'h0001) begin
          sampled <= di_level;
        end
        if (out_run && out_cnt == 16'h0001) begin
          o_transmit_process_image <= sampled;
          o_image_strobe           <= 1'b1;
        end
      end
    end
  end

  // Bit i of the image is input i+1: byte 0 holds inputs 1..8, byte 1 9..16
  // (the link sends byte 0 first)

  // ========================================================================
  // Status word: only the supply flags are live
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_io_status <= `IID_RST_WORD;
    end else begin
      o_io_status                         <= `IID_RST_WORD;
      o_io_status[`IID_IOS_UNDERVOLT_BIT] <= fault_now[`IID_SRC_UNDERVOLT];
      o_io_status[`IID_IOS_OVERLOAD_BIT]  <= fault_now[`IID_SRC_OVERCURRENT];
    end
  end

  // ========================================================================
  // Fault change detection: lowest waiting source enters the queue
  always @* begin
    enq     = 1'b0;
    enq_src = 2'h0;
    for (i = 3; i >= 0; i = i - 1) begin
      if (!pending[i] && fault_now[i] != reported[i]) begin
        enq     = 1'b1;
        enq_src = i[1:0];
      end
    end
  end

  assign deq     = (q_cnt != 3'h0) && !o_emcy_valid && !tx_start;
  assign deq_src = q_src[1:0];
  assign err_reg = {3'h0, reported[`IID_SRC_OVERTEMP], 1'b0,
                    reported[`IID_SRC_OVERCURRENT] | reported[`IID_SRC_SURGE] |
                    reported[`IID_SRC_UNDERVOLT], 2'h0};

  // Queue of source indices in order of occurrence
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      reported <= 4'h0;
      pending  <= 4'h0;
      q_src    <= 8'h00;
      q_cnt    <= 3'h0;
    end else begin
      if (enq) begin
        reported[enq_src] <= fault_now[enq_src];
        pending[enq_src]  <= 1'b1;
      end
      if (deq) begin
        pending[deq_src] <= 1'b0;
      end
      case ({enq, deq})
        2'b10: begin
          q_src[q_cnt[1:0]*2 +: 2] <= enq_src;
          q_cnt                    <= q_cnt + 3'h1;
        end
        2'b01: begin
          q_src <= {2'h0, q_src[7:2]};
          q_cnt <= q_cnt - 3'h1;
        end
        2'b11: begin
          q_src                           <= {2'h0, q_src[7:2]};
          q_src[(q_cnt[1:0]-2'h1)*2 +: 2] <= enq_src;
        end
        default: begin
        end
      endcase
    end
  end

  // ========================================================================
  // Message build: code, error register, five diagnostic bytes, LSB first
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_start <= 1'b0;
      tx_msg   <= 64'h0000_0000_0000_0000;
    end else begin
      tx_start <= deq;
      if (deq) begin
        tx_msg[15:0]  <= reported[deq_src] ? code_of(deq_src)
                                           : `IID_CODE_RESET;
        tx_msg[23:16] <= err_reg;
        tx_msg[31:24] <= 8'h00;
        tx_msg[39:32] <= diag_of(deq_src);
        tx_msg[63:40] <= 24'h00_0000;
      end
    end
  end

  // Serialiser sends byte 0 (code low) first
  iid_emcy_tx u_emcy (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_start   (tx_start),
    .i_msg     (tx_msg),
    .o_byte    (o_emcy_byte),
    .o_valid   (o_emcy_valid),
    .o_last    (o_emcy_last),
    .i_ready   (i_emcy_ready)
  );

  // ========================================================================
  // Interrupt status, write one to clear, set wins
  always @* begin
    irq_set                     = {`IID_IRQ_W{1'b0}};
    irq_set[`IID_IRQ_IMAGE_BIT] = o_image_strobe;
    irq_set[`IID_IRQ_EMCY_BIT]  = tx_start;
    irq_set[`IID_IRQ_FAULT_BIT] = enq;
  end

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_status <= {`IID_IRQ_W{1'b0}};
      o_irq      <= 1'b0;
    end else begin
      if (wr_now && i_avs_address == `IID_OFS_IRQ_STATUS) begin
        irq_status <= (irq_status & ~i_avs_writedata[`IID_IRQ_W-1:0]) | irq_set;
      end else begin
        irq_status <= irq_status | irq_set;
      end
      o_irq <= |(irq_status & irq_mask);
    end
  end

  // ========================================================================
  // Ready lamp: dark until boot, then steady or flashing
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flash_cnt   <= 32'h0000_0000;
      flash       <= 1'b0;
      o_ready_led <= 1'b0;
    end else begin
      if (flash_cnt >= FLASH_HALF - 1) begin
        flash_cnt <= 32'h0000_0000;
        flash     <= !flash;
      end else begin
        flash_cnt <= flash_cnt + 32'h0000_0001;
      end
      o_ready_led <= i_boot_done && (i_bus_operational || flash);
    end
  end

endmodule

// *** tb/iid_top_assertions.sv ***
// Port checker for iid_top: bus handshake, image, emergency stream, lamp.
// Assumes it is bound into iid_top and sees only that module's ports.
`timescale 1ns/1ns
module iid_chk (
  // Clock and reset
  input logic        i_clk_sys,
  input logic        i_rst_n,
  // Register bus
  input logic        i_avs_read,
  input logic        i_avs_write,
  input logic        o_avs_waitrequest,
  // Image and mode
  input logic        i_buffer_manager_event,
  input logic        o_image_strobe,
  input logic        o_mode_active,
  input logic        i_restart,
  input logic [31:0] o_io_status,
  // Emergency stream
  input logic [7:0]  o_emcy_byte,
  input logic        o_emcy_valid,
  input logic        o_emcy_last,
  input logic        i_emcy_ready,
  // Device level
  input logic        i_boot_done,
  input logic        i_bus_operational,
  input logic        o_ready_led,
  input logic        o_restore_defaults_req
);
  // ==========================
  // Properties
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  a_wait_one: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("no answer one cycle after request");
  a_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  a_bm_publish: assert property (!o_mode_active && i_buffer_manager_event |=> o_image_strobe)
    else $error("event not published");
  a_status_rsvd: assert property ((o_io_status & 32'hffff_ffcf) == 32'h0)
    else $error("reserved status bit set");
  a_emcy_hold: assert property (o_emcy_valid && !i_emcy_ready |=> o_emcy_valid && $stable(o_emcy_byte))
    else $error("byte dropped while stalled");
  a_mode_hold: assert property ($changed(o_mode_active) |-> $past(i_restart))
    else $error("mode changed without restart");
  a_led_steady: assert property (i_boot_done && i_bus_operational |=> o_ready_led)
    else $error("lamp not steady");
  a_restore_sticky: assert property (o_restore_defaults_req |=> o_restore_defaults_req)
    else $error("restore request lost");
  // Main scenarios
  c_last: cover property (o_emcy_last && i_emcy_ready);
  c_nt: cover property (o_image_strobe && o_mode_active);
  c_restore: cover property (o_restore_defaults_req);
endmodule
bind iid_top iid_chk i_chk (.*);

// *** tb/iid_link_sink.sv ***
// Link engine stand-in: takes emergency bytes and never replies.
// Assumes the iid_top byte stream; i_slow stalls ready.
`timescale 1ns/1ns
module iid_link_sink (
  // Clock and reset
  input  logic        i_clk_sys,
  input  logic        i_rst_n,
  // Stream
  input  logic        i_slow,
  input  logic [7:0]  i_byte,
  input  logic        i_valid,
  input  logic        i_last,
  output logic        o_ready,
  // Received message
  output logic [63:0] o_msg,
  output int          o_n_msg
);
  logic [1:0] ph;
  // Ready one cycle in four when slow
  assign o_ready = !i_slow || ph == 2'h3;
  // Shift bytes in, first byte lowest; no acknowledge goes back
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph      <= 2'h0;
      o_msg   <= 64'h0;
      o_n_msg <= 0;
    end else begin
      ph <= ph + 2'h1;
      if (i_valid && o_ready) begin
        o_msg <= {i_byte, o_msg[63:8]};
        if (i_last) begin
          o_n_msg <= o_n_msg + 1;
        end
      end
    end
  end
endmodule

// *** tb/tb_iid_top.sv ***
// Bench for iid_top: registers, image, emergency messages, sync mode, lamp.
// Assumes iid_link_sink takes the stream and iid_chk is bound.
`timescale 1ns/1ns
`include "iid_regs.vh"
module tb_iid_top;
  logic        i_clk_sys = 0, i_rst_n, i_avs_read, i_avs_write, i_clock_sync_pulse, i_buffer_manager_event;
  logic        i_restart, i_boot_done, i_bus_operational, i_emcy_ready, o_avs_waitrequest, o_irq, slow;
  logic        o_image_strobe, o_emcy_valid, o_emcy_last, o_mode_active, o_restore_defaults_req, o_ready_led;
  logic [4:0]  i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata, o_io_status, q;
  logic [15:0] i_digital_input, o_transmit_process_image;
  logic [7:0]  o_emcy_byte;
  logic [3:0]  f;
  logic [63:0] msg;
  wire         i_fault_overcurrent = f[0], i_fault_surge = f[1], i_fault_undervolt = f[2], i_fault_overtemp = f[3];
  int          miscompares = 0, n_checks = 0, n_msg, cyc = 0, l1, l2;
  logic [15:0] cd [4] = '{16'h3001, 16'h3002, 16'h3003, 16'h4001};
  logic [7:0]  dg [4] = '{8'h01, 8'h02, 8'h03, 8'h06};
  iid_top #(.FLASH_HALF(8)) i_dut (.*);
  iid_link_sink i_link (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_slow(slow), .i_byte(o_emcy_byte),
    .i_valid(o_emcy_valid), .i_last(o_emcy_last), .o_ready(i_emcy_ready), .o_msg(msg), .o_n_msg(n_msg));
  // ==========================
  // Clock and hang limit
  always #10 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      end_sim;
    end
  end
  // ==========================
  // Tasks
  task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge i_clk_sys);
    {i_avs_address, i_avs_writedata, i_avs_read, i_avs_write} <= {a, d, !wr, wr};
    do @(posedge i_clk_sys); while (o_avs_waitrequest !== 1'b0);
    r = o_avs_readdata;
    {i_avs_read, i_avs_write} <= 2'b00;
  endtask
  task exp_msg(input logic [63:0] e);
    int k;
    k = n_msg;
    wait (n_msg == k + 1);
    @(negedge i_clk_sys) chk("emcy", e, msg);
    @(posedge i_clk_sys);
  endtask
  task sync_lat(output int n);
    @(posedge i_clk_sys) i_clock_sync_pulse <= 1;
    n = 0;
    do begin @(posedge i_clk_sys); n++; end while (o_image_strobe !== 1'b1);
    i_clock_sync_pulse <= 0;
  endtask
  task end_sim;
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ==========================
  // Main sequence
  initial begin
    {i_rst_n, i_avs_read, i_avs_write, i_clock_sync_pulse, i_buffer_manager_event, i_restart} <= 0;
    {i_boot_done, i_bus_operational, slow, f, i_avs_address, i_avs_writedata, i_digital_input} <= 0;
    repeat (3) @(posedge i_clk_sys);
    i_rst_n <= 1;
    bus(0, `IID_OFS_CTRL, 0, q);
    chk("ctrl", 0, q);
    bus(0, `IID_OFS_IN_DELAY, 0, q);
    chk("in_delay", 1, q);
    chk("lamp", 0, o_ready_led);
    i_digital_input <= 16'ha53c;
    repeat (6) @(posedge i_clk_sys);
    i_buffer_manager_event <= 1;
    @(posedge i_clk_sys) i_buffer_manager_event <= 0;
    @(negedge i_clk_sys) chk("image", 16'ha53c, o_transmit_process_image);
    bus(0, `IID_OFS_IMAGE, 0, q);
    chk("image_reg", 32'h0000_a53c, q);
    for (int s = 0; s < 4; s++) begin
      slow <= s[0];
      f[s] <= 1;
      repeat (8) @(negedge i_clk_sys);
      chk("io_status", {26'h0, s == 2, s == 0, 4'h0}, o_io_status);
      @(posedge i_clk_sys) f[s] <= 0;
      exp_msg({24'h0, dg[s], 8'h0, (s == 3) ? 8'h10 : 8'h04, cd[s]});
      exp_msg({24'h0, dg[s], 32'h0});
    end
    @(negedge i_clk_sys) chk("irq", 0, o_irq);
    bus(1, `IID_OFS_IRQ_MASK, 7, q);
    repeat (2) @(negedge i_clk_sys);
    chk("irq", 1, o_irq);
    bus(1, `IID_OFS_IRQ_STATUS, 7, q);
    repeat (2) @(negedge i_clk_sys);
    chk("irq", 0, o_irq);
    bus(1, `IID_OFS_CTRL, 3, q);
    @(negedge i_clk_sys) chk("restore", 1, o_restore_defaults_req);
    chk("mode", 0, o_mode_active);
    @(posedge i_clk_sys) i_restart <= 1;
    @(posedge i_clk_sys) i_restart <= 0;
    i_buffer_manager_event <= 1;
    @(posedge i_clk_sys) i_buffer_manager_event <= 0;
    @(negedge i_clk_sys) chk("mode", 1, o_mode_active);
    chk("strobe", 0, o_image_strobe);
    bus(1, `IID_OFS_OUT_DELAY, 5, q);
    sync_lat(l1);
    bus(1, `IID_OFS_OUT_DELAY, 9, q);
    sync_lat(l2);
    chk("out_delay", 4, l2 - l1);
    chk("nt_image", 16'ha53c, o_transmit_process_image);
    {i_boot_done, i_bus_operational} <= 2'b11;
    repeat (3) @(posedge i_clk_sys);
    i_bus_operational <= 0;
    repeat (3) @(negedge i_clk_sys);
    q[0] = o_ready_led;
    repeat (8) @(negedge i_clk_sys);
    chk("flash", !q[0], o_ready_led);
    end_sim;
  end
endmodule
